/* sbst_pkg.sv */
`default_nettype none
package sbst_pkg;
   // ----------------------------------------------------------------
   // Instruction register
   // ----------------------------------------------------------------
   localparam int         IR_W        = 3;
   localparam logic [2:0] IR_EXTEST   = 3'h0;
   localparam logic [2:0] IR_IDCODE   = 3'h1;
   localparam logic [2:0] IR_SAMPLEZ  = 3'h2;
   localparam logic [2:0] IR_SAMPLE   = 3'h4;
   localparam logic [2:0] IR_BYPASS   = 3'h7;
   localparam logic [2:0] IR_RESET    = IR_IDCODE;
   localparam logic [2:0] IR_CAPTURE  = 3'h1;
   // ----------------------------------------------------------------
   // Data registers
   // ----------------------------------------------------------------
   localparam int          Q_W        = 36;
   localparam int          PAD_W      = Q_W + 2;
   localparam int          BSR_LEN    = 110;
   localparam int          CTRL_BIT   = 109;
   localparam int          IN_LSB     = PAD_W;
   localparam int          IN_W       = CTRL_BIT - PAD_W;
   localparam int          ID_W       = 32;
   // Arbitrary identification value; bit 0 set as the scan standard asks
   localparam logic [31:0] ID_VALUE   = 32'h0A5C_3E01;
   localparam logic [BSR_LEN-1:0] BSR_RESET = '0;

   typedef struct packed {
      logic           echo_clock_out;
      logic           echo_clock_out_n;
      logic [Q_W-1:0] q;
   } sbst_pad_t;

   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
   } sbst_state_t;
endpackage
`default_nettype wire

/* sbst_tap.sv */
// Behaviour
// - Tristate-sample forces read-data pins high impedance and captures pad values.
// - Output control status comes from boundary scan bit 109.
// - Control bit updates only in Update-DR under extest or sample.
// - Extest: echo clocks drive update data; read data driven if control 1, else Z.
// - Idcode, sample, bypass: pins carry normal memory output regardless of control.
// - Tristate-sample: echo-clock and read-data pins all high impedance.
// - Extest and tristate-sample: output cells capture actual pad levels.
// - Sample: echo cells capture internal; data cells internal when reading, else pad.
// - Output cell capture undefined under idcode and bypass.
// - Idcode loaded at reset and on each tck rise while in test-logic-reset.
// - Bypass loaded: single bypass bit between TDI and TDO in shift-DR.
`timescale 1ns/1ps
`default_nettype none
module sbst_tap
   import sbst_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   input  wire logic                 tck,
   input  wire logic                 tms,
   input  wire logic                 tdi,
   output logic                      tdo,
   output logic                      tdo_oe_n,
   input  wire sbst_pkg::sbst_pad_t  sram_out,
   input  wire logic                 sram_read,
   input  wire sbst_pkg::sbst_pad_t  pad_in,
   input  wire logic [sbst_pkg::IN_W-1:0] in_pads,
   output var sbst_pkg::sbst_pad_t   pad_out,
   output logic                      echo_oe_n,
   output logic                      q_oe_n
);
   import sbst_pkg::*;

   // ----------------------------------------------------------------
   // Synchronisers
   // ----------------------------------------------------------------
   logic [2:0]      tck_s;
   logic [1:0]      tms_s, tdi_s;
   sbst_pad_t       pad_s1, pad_s2;
   logic [IN_W-1:0] in_s1, in_s2;
   logic            tck_rise, tck_fall;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tck_s  <= '0;
         tms_s  <= 2'h3;
         tdi_s  <= 2'h3;
         pad_s1 <= '0;
         pad_s2 <= '0;
         in_s1  <= '0;
         in_s2  <= '0;
      end else begin
         tck_s  <= {tck_s[1:0], tck};
         tms_s  <= {tms_s[0], tms};
         tdi_s  <= {tdi_s[0], tdi};
         pad_s1 <= pad_in;
         pad_s2 <= pad_s1;
         in_s1  <= in_pads;
         in_s2  <= in_s1;
      end
   end

   // Edges found on stages two and three only
   assign tck_rise = tck_s[1] & ~tck_s[2];
   assign tck_fall = ~tck_s[1] & tck_s[2];

   // ----------------------------------------------------------------
   // TAP state, registers and pins
   // ----------------------------------------------------------------
   sbst_state_t          state, next_state;
   logic [IR_W-1:0]      ir, next_ir, ir_sh, next_ir_sh;
   logic [BSR_LEN-1:0]   bsr_sh, next_bsr_sh, upd, next_upd;
   logic [ID_W-1:0]      id_sh, next_id_sh;
   logic                 byp, next_byp;
   logic                 next_tdo, next_tdo_oe_n;
   sbst_pad_t            next_pad_out, cap_pad;
   logic                 next_echo_oe_n, next_q_oe_n;

   function automatic sbst_state_t tap_step(sbst_state_t s, logic m);
      case (s)
         TLR:     tap_step = m ? TLR    : RTI;
         RTI:     tap_step = m ? SEL_DR : RTI;
         SEL_DR:  tap_step = m ? SEL_IR : CAP_DR;
         CAP_DR:  tap_step = m ? EX1_DR : SH_DR;
         SH_DR:   tap_step = m ? EX1_DR : SH_DR;
         EX1_DR:  tap_step = m ? UPD_DR : PAU_DR;
         PAU_DR:  tap_step = m ? EX2_DR : PAU_DR;
         EX2_DR:  tap_step = m ? UPD_DR : SH_DR;
         UPD_DR:  tap_step = m ? SEL_DR : RTI;
         SEL_IR:  tap_step = m ? TLR    : CAP_IR;
         CAP_IR:  tap_step = m ? EX1_IR : SH_IR;
         SH_IR:   tap_step = m ? EX1_IR : SH_IR;
         EX1_IR:  tap_step = m ? UPD_IR : PAU_IR;
         PAU_IR:  tap_step = m ? EX2_IR : PAU_IR;
         EX2_IR:  tap_step = m ? UPD_IR : SH_IR;
         UPD_IR:  tap_step = m ? SEL_DR : RTI;
         default: tap_step = TLR;
      endcase
   endfunction

   always_comb begin
      next_state     = state;
      next_ir        = ir;
      next_ir_sh     = ir_sh;
      next_bsr_sh    = bsr_sh;
      next_upd       = upd;
      next_id_sh     = id_sh;
      next_byp       = byp;
      next_tdo       = tdo;
      next_tdo_oe_n  = tdo_oe_n;
      cap_pad        = pad_s2;
      if (ir == IR_SAMPLE) begin
         cap_pad.echo_clock_out   = sram_out.echo_clock_out;
         cap_pad.echo_clock_out_n = sram_out.echo_clock_out_n;
         cap_pad.q = sram_read ? sram_out.q : pad_s2.q;
      end
      if (tck_rise) begin
         next_state = tap_step(state, tms_s[1]);
         case (state)
            TLR:    next_ir = IR_RESET;
            CAP_IR: next_ir_sh = IR_CAPTURE;
            SH_IR:  next_ir_sh = {tdi_s[1], ir_sh[IR_W-1:1]};
            CAP_DR: begin
               case (ir)
                  IR_EXTEST, IR_SAMPLEZ, IR_SAMPLE: begin
                     // Pad or internal per instruction and read activity
                     next_bsr_sh[PAD_W-1:0] = cap_pad;
                     next_bsr_sh[IN_LSB +: IN_W] = in_s2;
                     next_bsr_sh[CTRL_BIT] = upd[CTRL_BIT];
                  end
                  IR_IDCODE: next_id_sh = ID_VALUE;
                  // Output cells left untouched: their content is undefined
                  default:   next_byp = 1'b0;
               endcase
            end
            SH_DR: begin
               case (ir)
                  IR_EXTEST, IR_SAMPLEZ, IR_SAMPLE:
                     next_bsr_sh = {tdi_s[1], bsr_sh[BSR_LEN-1:1]};
                  IR_IDCODE: next_id_sh = {tdi_s[1], id_sh[ID_W-1:1]};
                  // Reserved codes behave as bypass; never loaded by the tester
                  default:   next_byp = tdi_s[1];
               endcase
            end
            default: ;
         endcase
      end
      if (tck_fall) begin
         case (state)
            UPD_IR: next_ir = ir_sh;
            UPD_DR:
               if (ir == IR_EXTEST || ir == IR_SAMPLE)
                  next_upd = bsr_sh;
            default: ;
         endcase
         next_tdo_oe_n = !(state == SH_IR || state == SH_DR);
         if (state == SH_IR)
            next_tdo = ir_sh[0];
         else if (state == SH_DR) begin
            case (ir)
               IR_EXTEST, IR_SAMPLEZ, IR_SAMPLE: next_tdo = bsr_sh[0];
               IR_IDCODE: next_tdo = id_sh[0];
               default:   next_tdo = byp;
            endcase
         end
      end
      // Pin drive follows the instruction in force
      next_pad_out   = sram_out;
      next_echo_oe_n = 1'b0;
      next_q_oe_n    = !sram_read;
      case (ir)
         IR_EXTEST: begin
            next_pad_out = upd[PAD_W-1:0];
            next_q_oe_n  = !upd[CTRL_BIT];
         end
         IR_SAMPLEZ: begin
            next_echo_oe_n = 1'b1;
            next_q_oe_n    = 1'b1;
         end
         default: ;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state     <= TLR;
         ir        <= IR_RESET;
         ir_sh     <= '0;
         bsr_sh    <= BSR_RESET;
         upd       <= BSR_RESET;
         id_sh     <= '0;
         byp       <= 1'b0;
         tdo       <= 1'b0;
         tdo_oe_n  <= 1'b1;
         pad_out   <= '0;
         echo_oe_n <= 1'b1;
         q_oe_n    <= 1'b1;
      end else begin
         state     <= next_state;
         ir        <= next_ir;
         ir_sh     <= next_ir_sh;
         bsr_sh    <= next_bsr_sh;
         upd       <= next_upd;
         id_sh     <= next_id_sh;
         byp       <= next_byp;
         tdo       <= next_tdo;
         tdo_oe_n  <= next_tdo_oe_n;
         pad_out   <= next_pad_out;
         echo_oe_n <= next_echo_oe_n;
         q_oe_n    <= next_q_oe_n;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_ir_load;
      @(posedge clk) disable iff (!reset_n)
      (tck_fall && state == UPD_IR) |=> (ir == $past(ir_sh));
   endproperty
   a_ir_load: assert property (p_ir_load) else $error("IR not loaded");

   property p_samplez_hiz;
      @(posedge clk) disable iff (!reset_n)
      ($past(ir) == IR_SAMPLEZ) |-> (q_oe_n && echo_oe_n);
   endproperty
   a_samplez_hiz: assert property (p_samplez_hiz) else $error("pins driven");

   property p_extest_q;
      @(posedge clk) disable iff (!reset_n)
      ($past(ir) == IR_EXTEST) |-> (q_oe_n == !$past(upd[CTRL_BIT]) && !echo_oe_n
                                    && pad_out == $past(upd[PAD_W-1:0]));
   endproperty
   a_extest_q: assert property (p_extest_q) else $error("extest drive");

   property p_ctrl_upd;
      @(posedge clk) disable iff (!reset_n)
      (upd[CTRL_BIT] != $past(upd[CTRL_BIT])) |->
         ($past(tck_fall) && $past(state) == UPD_DR
          && ($past(ir) == IR_EXTEST || $past(ir) == IR_SAMPLE));
   endproperty
   a_ctrl_upd: assert property (p_ctrl_upd) else $error("control bit moved");

   property p_normal;
      @(posedge clk) disable iff (!reset_n)
      // Reset values still stand on the first edge after release
      $past(reset_n) && ($past(ir) == IR_IDCODE || $past(ir) == IR_BYPASS
                         || $past(ir) == IR_SAMPLE)
         |-> (pad_out == $past(sram_out) && q_oe_n == !$past(sram_read)
              && !echo_oe_n);
   endproperty
   a_normal: assert property (p_normal) else $error("normal path");

   property p_pad_cap;
      @(posedge clk) disable iff (!reset_n)
      (tck_rise && state == CAP_DR && (ir == IR_EXTEST || ir == IR_SAMPLEZ))
         |=> (bsr_sh[PAD_W-1:0] == $past(pad_s2));
   endproperty
   a_pad_cap: assert property (p_pad_cap) else $error("pad capture");

   property p_sample_cap;
      @(posedge clk) disable iff (!reset_n)
      (tck_rise && state == CAP_DR && ir == IR_SAMPLE && sram_read)
         |=> (bsr_sh[PAD_W-1:0] == $past(sram_out));
   endproperty
   a_sample_cap: assert property (p_sample_cap) else $error("sample capture");

   property p_tlr;
      @(posedge clk) disable iff (!reset_n)
      (tck_rise && state == TLR) |=> (ir == IR_IDCODE) ##1 (ir == IR_IDCODE);
   endproperty
   a_tlr: assert property (p_tlr) else $error("idcode not default");

   property p_bypass;
      @(posedge clk) disable iff (!reset_n)
      (tck_rise && state == SH_DR && ir == IR_BYPASS) |=> (byp == $past(tdi_s[1]));
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass shift");

   property p_tdo_fall;
      @(posedge clk) disable iff (!reset_n)
      (tdo != $past(tdo)) |-> $past(tck_fall);
   endproperty
   a_tdo_fall: assert property (p_tdo_fall) else $error("tdo off falling edge");
endmodule // sbst_tap
`default_nettype wire

/* sbst_jtag_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module sbst_jtag_ctrl (
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   // ----------------------------------------------------------------
   // Scan controller: tck idles low between frames
   // ----------------------------------------------------------------
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end

   // Mode and data move only while tck is low; tdo read just before the rise
   task automatic tick(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #16 o = tdo;
      tck = 1'b1;
      #16 tck = 1'b0;
   endtask

   task automatic reset_tap();
      logic o;
      repeat (5) tick(1'b1, 1'b0, o);
      tick(1'b0, 1'b0, o);
   endtask

   // Starts and ends in Run-Test/Idle; last bit leaves the shift state
   task automatic scan(input logic ir, input int n, input logic [109:0] din,
                       output logic [109:0] dout);
      logic o;
      dout = '0;
      tick(1'b1, 1'b0, o);
      if (ir) tick(1'b1, 1'b0, o);
      tick(1'b0, 1'b0, o);
      tick(1'b0, 1'b0, o);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], o);
         dout[i] = o;
      end
      tick(1'b1, 1'b0, o);
      tick(1'b0, 1'b0, o);
   endtask
endmodule // sbst_jtag_ctrl
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module testbench;
   import sbst_pkg::*;
   logic            clk, reset_n, tck, tms, tdi, tdo, tdo_oe_n;
   logic            sram_read, echo_oe_n, q_oe_n;
   sbst_pad_t       sram_out, pad_in, pad_out;
   logic [IN_W-1:0] in_pads;
   logic [109:0]    din, dout, upd;
   logic [2:0]      ir_m;
   int              err_count, samples_checked, seed;

   sbst_tap sbst_tap_i (.clk(clk), .reset_n(reset_n), .tck(tck), .tms(tms),
      .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .sram_out(sram_out),
      .sram_read(sram_read), .pad_in(pad_in), .in_pads(in_pads),
      .pad_out(pad_out), .echo_oe_n(echo_oe_n), .q_oe_n(q_oe_n));
   sbst_jtag_ctrl sbst_jtag_ctrl_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Model of capture source and pin drive
   // ----------------------------------------------------------------
   function automatic logic [109:0] cap_model();
      logic [37:0] c;
      c = (ir_m == IR_SAMPLE) ? sram_out : pad_in;
      if (ir_m == IR_SAMPLE && !sram_read) c[35:0] = pad_in.q;
      return {upd[109], in_pads, c};
   endfunction

   task automatic stim(input logic rd);
      @(negedge clk);
      sram_read = rd;
      sram_out = 38'({$random(seed), $random(seed)});
      pad_in = 38'({$random(seed), $random(seed)});
      in_pads = IN_W'({$random(seed), $random(seed), $random(seed)});
   endtask

   // Pins follow one clk after the update; margin covers tck sync depth
   task automatic check_pins();
      repeat (4) @(negedge clk);
      `CHK("tdo_oe_n", 1'b1, tdo_oe_n)
      if (ir_m == IR_SAMPLEZ) begin
         `CHK("echo_oe_n", 1'b1, echo_oe_n)
         `CHK("q_oe_n", 1'b1, q_oe_n)
      end else if (ir_m == IR_EXTEST) begin
         `CHK("pad_out", upd[37:0], pad_out)
         `CHK("echo_oe_n", 1'b0, echo_oe_n)
         `CHK("q_oe_n", ~upd[109], q_oe_n)
      end else begin
         `CHK("pad_out", sram_out, pad_out)
         `CHK("echo_oe_n", 1'b0, echo_oe_n)
         `CHK("q_oe_n", ~sram_read, q_oe_n)
      end
   endtask

   task automatic load_ir(input logic [2:0] code); // Listed codes only
      sbst_jtag_ctrl_i.scan(1'b1, 3, {107'h0, code}, dout);
      `CHK("ir_capture", IR_CAPTURE, dout[2:0])
      ir_m = code;
      check_pins();
   endtask

   task automatic dr(input int n, input logic c);
      din = 110'({$random(seed), $random(seed), $random(seed), $random(seed)});
      din[109] = c;
      sbst_jtag_ctrl_i.scan(1'b0, n, din, dout);
      case (ir_m)
         IR_IDCODE: `CHK("idcode", ID_VALUE, dout[31:0])
         IR_BYPASS: `CHK("bypass", {din[6:0], 1'b0}, dout[7:0])
         default: `CHK("capture", cap_model(), dout)
      endcase
      if (ir_m == IR_EXTEST || ir_m == IR_SAMPLE) upd = din;
      check_pins();
   endtask

   task automatic conclude();
      if (err_count == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      seed = 54;
      err_count = 0;
      samples_checked = 0;
      reset_n = 1'b0;
      sram_read = 1'b0;
      sram_out = '0;
      pad_in = '0;
      in_pads = '0;
      upd = '0;
      ir_m = IR_RESET;
      repeat (3) @(negedge clk);
      reset_n = 1'b1;
      repeat (3) @(negedge clk);
      `CHK("tdo_oe_n", 1'b1, tdo_oe_n)
      sbst_jtag_ctrl_i.reset_tap();
      stim(1'b1);
      dr(32, 1'b0);
      load_ir(IR_BYPASS);
      dr(8, 1'b1);
      load_ir(IR_SAMPLE);
      dr(110, 1'b1);
      stim(1'b0);
      dr(110, 1'b1);
      load_ir(IR_EXTEST);
      stim(1'b1);
      dr(110, 1'b0);
      dr(110, 1'b1);
      load_ir(IR_SAMPLEZ);
      stim(1'b0);
      dr(110, 1'b0);
      // Update under tristate-sample must leave the preload intact
      load_ir(IR_EXTEST);
      sbst_jtag_ctrl_i.reset_tap();
      ir_m = IR_RESET;
      dr(32, 1'b0);
      conclude();
   end

   // Scans take about 23 us; generous bound
   initial begin
      #200000;
      err_count++;
      conclude();
   end
endmodule // testbench
`default_nettype wire
